// [rtl/conv_ctrl_defines.vh]
`ifndef CONV_CTRL_DEFINES_VH
`define CONV_CTRL_DEFINES_VH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_MHZ        200
`define TCONV_CH_NS    500
`define CONV_TICK_CYC  ((`TCONV_CH_NS * `CLK_MHZ) / 1000)
`define WAKE_US        100
`define WAKE_CYC       (`WAKE_US * `CLK_MHZ)

// ----------------------------------------------------------------------
// Register word addresses (byte offsets)
// ----------------------------------------------------------------------
`define ADR_CTRL       8'h00
`define ADR_STATUS     8'h04
`define ADR_LSB        8'h08
`define ADR_IRQ_STAT   8'h0c
`define ADR_IRQ_CLR    8'h10
`define ADR_IRQ_EN     8'h14
`define ADR_CONV_CNT   8'h18
`define RES_BASE_HI    3'h2

// ----------------------------------------------------------------------
// Fields and values
// ----------------------------------------------------------------------
`define VAR_8CH        2'h0
`define VAR_6CH        2'h1
`define VAR_4CH        2'h2
`define NCH_8          4'h8
`define NCH_6          4'h6
`define NCH_4          4'h4
`define CTRL_RST       2'h0
`define LSB_NV_WIDE    32'h0004a818
`define LSB_NV_NARROW  32'h0002540c
`define IRQ_W          3
`define IRQ_DONE       0
`define IRQ_DROP       1
`define IRQ_WAKE       2
`define SYNC_RST       5'h04

// ----------------------------------------------------------------------
// Power states
// ----------------------------------------------------------------------
`define PW_ON          3'h0
`define PW_POWER_DOWN_N        3'h1
`define PW_SHUT        3'h2
`define PW_WAKE        3'h3
`define PW_DEAD        3'h4

`endif

// [rtl/pin_sync.v]
`timescale 1ns/1ps
`include "conv_ctrl_defines.vh"

module pin_sync #(
  parameter W = 5
) (
  // Clock and reset.
  input  wire         clk_i,
  input  wire         rst_i,
  // Asynchronous pins.
  input  wire [W-1:0] pins_i,
  // Synchronised levels and rising edges.
  output wire [W-1:0] level_o,
  output wire [W-1:0] rise_o
);

  reg [W-1:0] meta_ff;
  reg [W-1:0] sync_ff;
  reg [W-1:0] prev_ff;

  // Two flip-flops per pin, then one more for edge detection.
  always @(posedge clk_i) begin
    if (rst_i) begin
      meta_ff <= `SYNC_RST;
      sync_ff <= `SYNC_RST;
      prev_ff <= `SYNC_RST;
    end else begin
      meta_ff <= pins_i;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  // Edges are taken only from the second and third stages.
  assign level_o = sync_ff;
  assign rise_o  = sync_ff & ~prev_ff;

endmodule

// [rtl/result_ram.v]
`timescale 1ns/1ps

module result_ram (
  // Clock.
  input  wire        clk_i,
  // Write port.
  input  wire        we_i,
  input  wire [3:0]  waddr_i,
  input  wire [15:0] wdata_i,
  // Read port.
  input  wire [3:0]  raddr_i,
  output reg  [15:0] rdata_o
);

  reg [15:0] mem [0:15];

  // Synchronous write and registered read.
  always @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end

endmodule

// [rtl/sim_conv_ctrl.v]
// Behaviour
// R1: Trigger rising edge puts its track-and-holds into hold at once.
// R2: Busy rises with the trigger and falls when all channels are converted.
// R3: Busy falling returns all track-and-holds to track; acquisition starts.
// R4: Internal conversion clock; 4, 3 or 2 us for 8, 6 or 4 channels.
// R5: Reads during busy return the previous completed result set.
// R6: Every result is a 16-bit two's complement code.
// R7: One step is full scale over 65536; transitions sit at half steps.
// R8: Step weight follows the selected input range.
// R9: Reference select high enables internal reference; low needs external.
// R10: After reset the reference mode follows the reference select input.
// R11: Power-down low enters standby if range is 1, shutdown if 0.
// R12: Standby keeps reference on, cores off; 100 us to wake.
// R13: After shutdown the host waits 13 ms then applies reset.
// R14: A common trigger on both inputs samples all channels together.
// R15: Busy falling marks new results available on every read-out path.
// R16: Separate triggers hold their own sets; busy starts at the later edge.
// R17: Trigger edges during busy are ignored and do not disturb conversion.
//
// Chosen here: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
`include "conv_ctrl_defines.vh"

module sim_conv_ctrl #(
  parameter WAKE_CYCLES = `WAKE_CYC
) (
  // Clock and reset.
  input  wire        clk_i,
  input  wire        rst_i,
  // Wishbone slave.
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire        wb_ack_o,
  // Control pins.
  input  wire        sample_trigger_first_set_i,
  input  wire        sample_trigger_second_set_i,
  input  wire        power_down_n_i,
  input  wire        range_i,
  input  wire        ref_select_i,
  // Converter core.
  input  wire [16:0] conv_code_i,
  output wire [2:0]  conv_ch_o,
  // Status and analog controls.
  output wire        busy_o,
  output wire        hold_first_o,
  output wire        hold_second_o,
  output wire        ref_internal_en_o,
  output wire        ref_power_o,
  output wire        core_power_o,
  output wire        irq_o
);

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  // Channels converted for a device variant.
  function [3:0] chan_count;
    input [1:0] variant;
    begin
      case (variant)
        `VAR_6CH: chan_count = `NCH_6;
        `VAR_4CH: chan_count = `NCH_4;
        default:  chan_count = `NCH_8;
      endcase
    end
  endfunction

  // Rounds a half-step offset-binary code and flips it to two's complement.
  function [15:0] to_twos;
    input [16:0] raw;
    reg   [17:0] sum;
    reg   [15:0] code;
    begin
      sum  = {1'b0, raw} + 18'h00001;
      code = sum[17] ? 16'hffff : sum[16:1];
      to_twos = {~code[15], code[14:0]};
    end
  endfunction

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  wire [4:0] lvl;
  wire [4:0] rise;

  pin_sync #(
    .W (5)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pins_i  ({ref_select_i, range_i, power_down_n_i,
               sample_trigger_second_set_i, sample_trigger_first_set_i}),
    .level_o (lvl),
    .rise_o  (rise)
  );

  wire trig1_rise = rise[0];
  wire trig2_rise = rise[1];
  wire pdn_n      = lvl[2];
  wire range_lvl  = lvl[3];
  wire ref_sel    = lvl[4];

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  localparam TICK_LAST = `CONV_TICK_CYC - 1;
  reg [2:0]         pw_ff;
  reg [2:0]         nxt_pw;
  reg [14:0]        wake_ff;
  reg               busy_ff;
  reg               hold1_ff;
  reg               hold2_ff;
  reg [2:0]         ch_ff;
  reg [6:0]         div_ff;
  reg               rd_bank_ff;
  reg               valid_ff;
  reg [15:0]        conv_cnt_ff;
  reg [1:0]         ctrl_ff;
  reg               ref_en_ff;
  reg               ref_pwr_ff;
  reg               core_pwr_ff;
  reg [`IRQ_W-1:0]  irq_st_ff;
  reg [`IRQ_W-1:0]  irq_en_ff;
  reg               irq_ff;
  reg               pend_ff;
  reg               ack_ff;
  reg [31:0]        dat_ff;

  wire       ready     = (pw_ff == `PW_ON);
  wire       accept    = ready & ~busy_ff;
  wire       tick      = busy_ff & (div_ff == TICK_LAST[6:0]);
  wire [3:0] last_ch   = chan_count(ctrl_ff) - 4'h1;
  wire       last_tick = tick & ({1'b0, ch_ff} == last_ch);
  wire       hold1_now = hold1_ff | (trig1_rise & accept);
  wire       hold2_now = hold2_ff | (trig2_rise & accept);
  wire       start     = accept & hold1_now & hold2_now;
  wire       drop1     = trig1_rise & (~accept | hold1_ff);
  wire       drop2     = trig2_rise & (~accept | hold2_ff);
  wire       wake_done = (pw_ff == `PW_WAKE) & (wake_ff == WAKE_CYCLES - 1);

  // ----------------------------------------------------------------------
  // Power modes
  // ----------------------------------------------------------------------
  // Next power state from the power-down pin and the range pin.
  always @* begin
    nxt_pw = pw_ff;
    case (pw_ff)
      `PW_ON, `PW_WAKE: begin
        if (!pdn_n) begin
          nxt_pw = range_lvl ? `PW_POWER_DOWN_N : `PW_SHUT; // see R11
        end else if (wake_done) begin
          nxt_pw = `PW_ON; // see R12
        end
      end
      `PW_POWER_DOWN_N: begin
        if (pdn_n) begin
          nxt_pw = `PW_WAKE; // see R12
        end
      end
      `PW_SHUT: begin
        if (pdn_n) begin
          nxt_pw = `PW_DEAD; // see R13
        end
      end
      `PW_DEAD: begin
        nxt_pw = `PW_DEAD;
      end
      default: begin
        nxt_pw = `PW_ON;
      end
    endcase
  end

  // Power state, wake timer and power enables.
  always @(posedge clk_i) begin
    if (rst_i) begin
      pw_ff       <= `PW_ON;
      wake_ff     <= 15'h0000;
      ref_en_ff   <= 1'b0;
      ref_pwr_ff  <= 1'b0;
      core_pwr_ff <= 1'b0;
    end else begin
      pw_ff       <= nxt_pw;
      wake_ff     <= (pw_ff == `PW_WAKE) ? wake_ff + 15'h0001 : 15'h0000;
      ref_en_ff   <= ref_sel & (nxt_pw != `PW_SHUT);        // see R9, R10
      ref_pwr_ff  <= (nxt_pw != `PW_SHUT);                  // see R12
      core_pwr_ff <= (nxt_pw != `PW_SHUT) & (nxt_pw != `PW_POWER_DOWN_N); // see R12
    end
  end

  // ----------------------------------------------------------------------
  // Sampling and conversion
  // ----------------------------------------------------------------------
  // Track-and-hold, busy, conversion clock and channel sequencing.
  always @(posedge clk_i) begin
    if (rst_i) begin
      busy_ff     <= 1'b0;
      hold1_ff    <= 1'b0;
      hold2_ff    <= 1'b0;
      ch_ff       <= 3'h0;
      div_ff      <= 7'h00;
      rd_bank_ff  <= 1'b0;
      valid_ff    <= 1'b0;
      conv_cnt_ff <= 16'h0000;
    end else if (!ready) begin
      busy_ff  <= 1'b0;
      hold1_ff <= 1'b0;
      hold2_ff <= 1'b0;
    end else if (!busy_ff) begin
      hold1_ff <= hold1_now;   // see R1, R14, R16
      hold2_ff <= hold2_now;   // see R1, R14, R16
      if (start) begin
        busy_ff <= 1'b1;       // see R2, R16
        ch_ff   <= 3'h0;
        div_ff  <= 7'h00;
      end
    end else begin
      div_ff <= tick ? 7'h00 : div_ff + 7'h01; // see R4
      if (last_tick) begin
        busy_ff     <= 1'b0;   // see R2
        hold1_ff    <= 1'b0;   // see R3
        hold2_ff    <= 1'b0;   // see R3
        rd_bank_ff  <= ~rd_bank_ff; // see R5, R15
        valid_ff    <= 1'b1;
        conv_cnt_ff <= conv_cnt_ff + 16'h0001;
      end else if (tick) begin
        ch_ff <= ch_ff + 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Result storage
  // ----------------------------------------------------------------------
  wire [15:0] res_rdata;
  wire        res_sel = (wb_adr_i[7:5] == `RES_BASE_HI);

  // New results go to the bank that software is not reading.
  result_ram u_ram (
    .clk_i   (clk_i),
    .we_i    (tick & ready),
    .waddr_i ({~rd_bank_ff, ch_ff}),     // see R5
    .wdata_i (to_twos(conv_code_i)),     // see R6, R7
    .raddr_i ({rd_bank_ff, wb_adr_i[4:2]}),
    .rdata_o (res_rdata)
  );

  // ----------------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------------
  wire [`IRQ_W-1:0] irq_ev;
  wire              clr_wr;
  wire [`IRQ_W-1:0] nxt_irq_st;

  assign irq_ev[`IRQ_DONE] = last_tick & ready;
  assign irq_ev[`IRQ_DROP] = drop1 | drop2;   // see R17
  assign irq_ev[`IRQ_WAKE] = wake_done & pdn_n;

  assign clr_wr     = pend_ff & wb_we_i & wb_sel_i[0] & (wb_adr_i == `ADR_IRQ_CLR);
  assign nxt_irq_st = (irq_st_ff & ~(clr_wr ? wb_dat_i[`IRQ_W-1:0] : {`IRQ_W{1'b0}})) | irq_ev;

  // Sticky status with set winning over clear.
  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_st_ff <= {`IRQ_W{1'b0}};
      irq_ff    <= 1'b0;
    end else begin
      irq_st_ff <= nxt_irq_st;
      irq_ff    <= |(nxt_irq_st & irq_en_ff);
    end
  end

  // ----------------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------------
  wire        req = wb_cyc_i & wb_stb_i & ~pend_ff & ~ack_ff;
  wire        wr  = pend_ff & wb_we_i & wb_sel_i[0];
  reg  [31:0] rd_mux;

  // Read data selection.
  always @* begin
    rd_mux = 32'h00000000;
    if (res_sel) begin
      rd_mux = valid_ff ? {16'h0000, res_rdata} : 32'h00000000; // see R5
    end else begin
      case (wb_adr_i)
        `ADR_CTRL:     rd_mux = {30'h00000000, ctrl_ff};
        `ADR_STATUS:   rd_mux = {21'h000000, pw_ff, 1'b0, (pw_ff == `PW_DEAD), ready,
                                 range_lvl, ref_en_ff, hold2_ff, hold1_ff, busy_ff};
        `ADR_LSB:      rd_mux = range_lvl ? `LSB_NV_WIDE : `LSB_NV_NARROW; // see R8
        `ADR_IRQ_STAT: rd_mux = {29'h00000000, irq_st_ff};
        `ADR_IRQ_EN:   rd_mux = {29'h00000000, irq_en_ff};
        `ADR_CONV_CNT: rd_mux = {16'h0000, conv_cnt_ff};
        default:       rd_mux = 32'h00000000;
      endcase
    end
  end

  // Two-stage answer: read memory, then register data and ack.
  always @(posedge clk_i) begin
    if (rst_i) begin
      pend_ff   <= 1'b0;
      ack_ff    <= 1'b0;
      dat_ff    <= 32'h00000000;
      ctrl_ff   <= `CTRL_RST;
      irq_en_ff <= {`IRQ_W{1'b0}};
    end else begin
      pend_ff <= req;
      ack_ff  <= pend_ff;
      if (pend_ff) begin
        dat_ff <= wb_we_i ? 32'h00000000 : rd_mux;
      end
      if (wr && wb_adr_i == `ADR_CTRL && !busy_ff) begin
        ctrl_ff <= wb_dat_i[1:0];
      end
      if (wr && wb_adr_i == `ADR_IRQ_EN) begin
        irq_en_ff <= wb_dat_i[`IRQ_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign wb_dat_o          = dat_ff;
  assign wb_ack_o          = ack_ff;
  assign conv_ch_o         = ch_ff;
  assign busy_o            = busy_ff;
  assign hold_first_o      = hold1_ff;
  assign hold_second_o     = hold2_ff;
  assign ref_internal_en_o = ref_en_ff;
  assign ref_power_o       = ref_pwr_ff;
  assign core_power_o      = core_pwr_ff;
  assign irq_o             = irq_ff;

endmodule

// [tb/conv_checker.sv]
`timescale 1ns/1ps
// Watches the conversion control ports for sequencing faults.
module conv_checker (
  // Clock and reset.
  input wire       clk_i,
  input wire       rst_i,
  // Bus handshake.
  input wire       wb_cyc_i,
  input wire       wb_stb_i,
  input wire       wb_ack_o,
  // Control pins.
  input wire       sample_trigger_first_set_i,
  input wire       sample_trigger_second_set_i,
  input wire       power_down_n_i,
  input wire       range_i,
  input wire       ref_select_i,
  // Status outputs.
  input wire [2:0] conv_ch_o,
  input wire       busy_o,
  input wire       hold_first_o,
  input wire       hold_second_o,
  input wire       ref_internal_en_o,
  input wire       ref_power_o,
  input wire       core_power_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [9:0] busy_cnt_ff;
  // Counts the edges at which busy was seen high.
  always @(posedge clk_i) busy_cnt_ff <= (rst_i || !busy_o) ? 10'h000 : busy_cnt_ff + 10'h001;
  hold_in_busy_a: assert property (
    busy_o |-> hold_first_o && hold_second_o) else $error("Busy without both holds.");
  busy_start_a: assert property (
    $rose(sample_trigger_first_set_i && sample_trigger_second_set_i) && !busy_o && !hold_first_o
    && !hold_second_o && core_power_o |-> ##[2:5] busy_o) else $error("Trigger did not start busy.");
  track_on_fall_a: assert property (
    $fell(busy_o) |-> !hold_first_o && !hold_second_o) else $error("Holds outlived busy.");
  conv_time_a: assert property (
    $fell(busy_o) && power_down_n_i |-> busy_cnt_ff inside {10'h320, 10'h258, 10'h190})
    else $error("Busy length wrong.");
  chan_step_a: assert property (
    busy_o && $past(busy_o) |-> conv_ch_o == $past(conv_ch_o) || conv_ch_o == $past(conv_ch_o) + 3'h1)
    else $error("Channel skipped.");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("Ack longer than one cycle.");
  ack_delay_a: assert property ($rose(wb_cyc_i && wb_stb_i) |-> ##2 wb_ack_o) else $error("Ack late.");
  standby_entry_a: assert property (
    $fell(power_down_n_i) && range_i |-> ##[2:6] !core_power_o && ref_power_o) else $error("No standby.");
  shutdown_entry_a: assert property (
    $fell(power_down_n_i) && !range_i |-> ##[2:6] !core_power_o && !ref_power_o) else $error("No shutdown.");
  ref_on_a: assert property (
    (ref_select_i && ref_power_o)[*8] |-> ref_internal_en_o) else $error("Internal reference off.");
  ref_off_a: assert property (
    (!ref_select_i)[*8] |-> !ref_internal_en_o) else $error("Internal reference on.");
  cover property ($fell(busy_o));
  cover property ($rose(hold_first_o) && !hold_second_o);
  cover property ($fell(core_power_o) && ref_power_o);
endmodule
bind sim_conv_ctrl conv_checker i_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .sample_trigger_first_set_i, .sample_trigger_second_set_i, .power_down_n_i, .range_i, .ref_select_i,
  .conv_ch_o, .busy_o, .hold_first_o, .hold_second_o, .ref_internal_en_o, .ref_power_o, .core_power_o);

// [tb/core_model.sv]
`timescale 1ns/1ps
// Converter core stand-in that feeds raw half-step samples.
module core_model (
  // Clock.
  input  wire         clk_i,
  // Conversion progress.
  input  wire         busy_i,
  input  wire  [2:0]  conv_ch_i,
  input  wire  [16:0] base_i,
  // Raw sample.
  output logic [16:0] conv_code_o
);
  logic [16:0] last_ff = 17'h00000;
  // Outside a conversion the output is junk, so it flips every cycle.
  always @(posedge clk_i) last_ff <= ~conv_code_o;
  // While busy each channel shows its own held sample.
  always @* conv_code_o = busy_i ? base_i + 17'h01111 * conv_ch_i : last_ff;
endmodule

// [tb/testbench.sv]
`timescale 1ns/1ps
`include "conv_ctrl_defines.vh"
module testbench;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  logic        sample_trigger_first_set_i = 1'b0, sample_trigger_second_set_i = 1'b0;
  logic        power_down_n_i = 1'b1, range_i = 1'b1, ref_select_i = 1'b1;
  logic [16:0] base = 17'h0;
  wire  [31:0] wb_dat_o;
  wire  [16:0] conv_code_i;
  wire  [2:0]  conv_ch_o;
  wire         wb_ack_o, busy_o, hold_first_o, hold_second_o, ref_internal_en_o, ref_power_o, core_power_o, irq_o;
  int          errors = 0, comparisons = 0, n, k, i, v, c;
  logic [7:0]  seed = 8'h38;
  logic [15:0] prev [8];
  logic [31:0] q;
  // Clock at 200 MHz.
  always #2.5 clk_i = ~clk_i;
  sim_conv_ctrl #(.WAKE_CYCLES(20)) i_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .sample_trigger_first_set_i, .sample_trigger_second_set_i, .power_down_n_i,
    .range_i, .ref_select_i, .conv_code_i, .conv_ch_o, .busy_o, .hold_first_o, .hold_second_o, .ref_internal_en_o,
    .ref_power_o, .core_power_o, .irq_o);
  core_model i_core (.clk_i, .busy_i(busy_o), .conv_ch_i(conv_ch_o), .base_i(base), .conv_code_o(conv_code_i));
  // Next value of the stimulus shift register.
  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction
  // Rounds a half-step sample, saturates it and turns it into two's complement.
  function automatic logic [15:0] exp_code(input logic [16:0] r);
    logic [17:0] s;
    s = ({1'b0, r} + 18'h1) >> 1;
    if (s > 18'h0ffff) s = 18'h0ffff;
    return s[15:0] ^ 16'h8000;
  endfunction
  // Compares one value and counts the outcome.
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task automatic test_done;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic tick(input int t);
    repeat (t) @(posedge clk_i);
  endtask
  // One classic bus cycle; the request stands until ack is sampled.
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                    input logic [3:0] s = 4'hf);
    int t;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i, wb_adr_i, wb_dat_i} <= {2'b11, we, s, a, d};
    t = 0;
    do begin
      @(posedge clk_i);
      t++;
    end while (wb_ack_o !== 1'b1 && t < 50);
    r = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    if (t >= 50) chk("ack", 0, 1);
  endtask
  // Raises the triggers gap cycles apart, retriggers mid-busy and counts busy cycles.
  task automatic conv(input int gap, output int cnt);
    @(posedge clk_i);
    sample_trigger_first_set_i <= 1'b1;
    tick(gap);
    if (gap > 0) chk("early busy", busy_o, 0);
    if (gap > 0) chk("first hold", hold_first_o, 1);
    sample_trigger_second_set_i <= 1'b1;
    cnt = 0;
    n = 0;
    while (busy_o !== 1'b1 && n < 40) begin
      @(negedge clk_i);
      n++;
    end
    while (busy_o === 1'b1 && cnt < 1000) begin
      cnt++;
      @(posedge clk_i);
      sample_trigger_first_set_i <= (cnt >= 200 && cnt < 220);
      sample_trigger_second_set_i <= (cnt >= 200 && cnt < 220);
      @(negedge clk_i);
    end
  endtask
  // Cuts a hang short.
  initial begin
    tick(30000);
    errors++;
    test_done;
  end
  initial begin
    for (i = 0; i < 8; i++) prev[i] = 16'h0;
    tick(3);
    rst_i <= 1'b0;
    wb(0, `ADR_CTRL, 0, q);
    chk("ctrl", q, {30'h0, `CTRL_RST});
    for (k = 0; k < 2; k++) begin
      range_i <= k[0];
      tick(6);
      wb(0, `ADR_LSB, 0, q);
      chk("lsb", q, k ? `LSB_NV_WIDE : `LSB_NV_NARROW);
    end
    wb(0, 8'h30, 0, q);
    chk("unmapped", q, 0);
    wb(0, 8'h40, 0, q);
    chk("empty", q, 0);
    wb(1, `ADR_CTRL, 2, q, 4'h0);
    wb(0, `ADR_CTRL, 0, q);
    chk("no lane", q, 0);
    for (k = 0; k < 6; k++) begin
      v = k % 3;
      seed = lfsr(seed);
      base = (k == 0) ? 17'h00000 : (k == 1) ? 17'h1ffff : {seed, seed[0], seed};
      wb(1, `ADR_CTRL, v, q);
      wb(1, `ADR_IRQ_EN, k != 5, q);
      conv(k < 3 ? 0 : 12 + seed[3:0], c);
      chk("busy cycles", c, (8 - 2 * v) * 100);
      tick(12);
      chk("no restart", busy_o, 0);
      chk("irq", irq_o, k != 5);
      for (i = 0; i < 8 - 2 * v; i++) begin
        wb(0, 8'h40 + 4 * i, 0, q);
        prev[i] = exp_code(base + 17'h01111 * i);
        chk("result", q, {16'h0, prev[i]});
      end
      wb(0, `ADR_IRQ_STAT, 0, q);
      chk("irq status", q, 3);
      wb(1, `ADR_IRQ_CLR, 7, q);
      wb(0, `ADR_CONV_CNT, 0, q);
      chk("count", q, k + 1);
      chk("irq clear", irq_o, 0);
    end
    power_down_n_i <= 1'b0;
    tick(8);
    chk("standby core", core_power_o, 0);
    chk("standby ref", ref_power_o, 1);
    power_down_n_i <= 1'b1;
    tick(40);
    wb(0, `ADR_IRQ_STAT, 0, q);
    chk("wake", q, 4);
    for (k = 0; k < 2; k++) begin
      range_i <= 1'b0;
      power_down_n_i <= 1'b0;
      tick(8);
      chk("shutdown", {ref_power_o, core_power_o}, 0);
      power_down_n_i <= 1'b1;
      ref_select_i <= k[0];
      tick(20);
      rst_i <= 1'b1;
      tick(3);
      rst_i <= 1'b0;
      range_i <= 1'b1;
      tick(8);
      chk("revived", {ref_power_o, core_power_o}, 3);
      chk("ref mode", ref_internal_en_o, k);
    end
    // Reset leaves no completed set, so the first read in busy gives 0 and the second the first set.
    for (k = 0; k < 2; k++) begin
      prev[0] = k ? exp_code(base) : 16'h0;
      base = base ^ 17'h0aaaa;
      sample_trigger_first_set_i <= 1'b1;
      sample_trigger_second_set_i <= 1'b1;
      tick(8);
      wb(0, 8'h40, 0, q);
      chk("old result", q, {16'h0, prev[0]});
      chk("still busy", busy_o, 1);
      {sample_trigger_first_set_i, sample_trigger_second_set_i} <= 2'b00;
      wb(1, `ADR_CTRL, 2, q);
      wb(0, `ADR_CTRL, 0, q);
      chk("ctrl in busy", q, {30'h0, `CTRL_RST});
      tick(900);
      wb(0, 8'h40, 0, q);
      chk("new result", q, {16'h0, exp_code(base)});
    end
    test_done;
  end
endmodule
